// *** caf_cal_chan.sv ***
// One current channel: raw source pick, offset removal and gain
`timescale 1ns/1ps
`include "caf_cfg.svh"
module caf_cal_chan (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] source_sel,
    input wire logic [15:0] modulator0_result,
    input wire logic [15:0] modulator1_result,
    input wire logic [15:0] host_current0_value,
    input wire logic [15:0] host_current1_value,
    input wire logic [15:0] offset,
    input wire logic signed [15:0] gain,
    output logic [15:0] raw_current,
    output logic signed [15:0] cal_current
);
    logic [15:0] raw_d;
    logic signed [16:0] diff;
    logic signed [33:0] product;
    logic signed [33:0] scaled;

    always_comb begin
        case (source_sel)
            caf_pkg::CAF_RAW_MOD0: raw_d = modulator0_result;
            caf_pkg::CAF_RAW_MOD1: raw_d = modulator1_result;
            caf_pkg::CAF_RAW_HOST0: raw_d = host_current0_value;
            caf_pkg::CAF_RAW_HOST1: raw_d = host_current1_value;
            default: raw_d = modulator0_result;
        endcase
    end

    // Offset first, then signed gain
    assign diff = $signed({1'b0, raw_current}) - $signed({1'b0, offset});
    assign product = 34'(diff * gain);
    assign scaled = product >>> `CAF_GAIN_SHIFT;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            raw_current <= 16'h0000;
        end else begin
            raw_current <= raw_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cal_current <= 16'sh0000;
        end else begin
            cal_current <= scaled[15:0];
        end
    end
endmodule : caf_cal_chan

// *** caf_cfg.svh ***
// Register offsets, field positions, reset values and gain shift of the current front end
`ifndef CAF_CFG_SVH
`define CAF_CFG_SVH

`define CAF_ADDR_W 7
`define CAF_IDX_MOD_A_DIV 7'h05
`define CAF_IDX_MOD_B_DIV 7'h06
`define CAF_IDX_DECIM 7'h07
`define CAF_IDX_CAL1 7'h08
`define CAF_IDX_CAL0 7'h09
`define CAF_IDX_ROUTING 7'h0a
`define CAF_IDX_HOST_CUR 7'h0b
`define CAF_IDX_STAGE_CFG 7'h0c
`define CAF_IDX_CAL_STATUS 7'h0d

`define CAF_LO16_MSB 15
`define CAF_LO16_LSB 0
`define CAF_HI16_MSB 31
`define CAF_HI16_LSB 16
`define CAF_RAW0_SEL_MSB 7
`define CAF_RAW0_SEL_LSB 0
`define CAF_RAW1_SEL_MSB 15
`define CAF_RAW1_SEL_LSB 8
`define CAF_PH_A_SEL_MSB 25
`define CAF_PH_A_SEL_LSB 24
`define CAF_PH_B_SEL_MSB 27
`define CAF_PH_B_SEL_LSB 26
`define CAF_PH_C_SEL_MSB 29
`define CAF_PH_C_SEL_LSB 28
`define CAF_STAGE_MSB 3
`define CAF_STAGE_LSB 0

`define CAF_RST_MOD_DIV 32'h0000_0000
`define CAF_RST_DECIM 32'h0000_0000
`define CAF_RST_CAL 32'h0100_0000
`define CAF_RST_ROUTING 32'h1400_0100
`define CAF_RST_HOST_CUR 32'h0000_0000
`define CAF_RST_STAGE 4'h0

// Gain of 0x0100 is unity
`define CAF_GAIN_SHIFT 8

`endif

// *** caf_frontend.sv ***
// Current measurement front end configuration and routing
//
// Contract
// - Each modulator clock comes from its own 32-bit divider register.
// - Decimation A in 15:0, B in 31:16; zero follows the PWM period.
// - Channel 1 offset in 15:0, signed gain in 31:16.
// - Channel 0 offset in 15:0, signed gain in 31:16, separate register.
// - Raw channel 0 source in 7:0: modulator 0/1, host value 0/1.
// - Raw channel 1 source in 15:8, same four codes.
// - Phase A pick in 25:24: current 0, 1 or derived; default 0.
// - Phase B pick in 27:26: current 0, 1 or derived.
// - Phase C pick in 29:28: current 0, 1 or derived; default current 1.
// - A derived third current is formed from the two measured currents.
// - Host current register: value 0 in 15:0, value 1 in 31:16.
// - Four-bit input stage selector for channel 0 test configurations.
`timescale 1ns/1ps
`include "caf_cfg.svh"
module caf_frontend (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [15:0] modulator0_result,
    input wire logic [15:0] modulator1_result,
    input wire logic pwm_period_pulse,
    output logic mod_a_clk,
    output logic mod_b_clk,
    output logic filter_a_dec_strobe,
    output logic filter_b_dec_strobe,
    output logic signed [15:0] phase_a_current,
    output logic signed [15:0] phase_b_current,
    output logic signed [15:0] phase_c_current,
    output logic signed [15:0] derived_third_current,
    output logic [3:0] input_stage_config
);
    logic [31:0] mod_a_clock_divider_q;
    logic [31:0] mod_b_clock_divider_q;
    logic [31:0] decim_q;
    logic [31:0] cal1_q;
    logic [31:0] cal0_q;
    logic [31:0] routing_q;
    logic [31:0] host_cur_q;
    logic [3:0] stage_q;

    logic [31:0] div_a_cnt_q;
    logic [31:0] div_b_cnt_q;
    logic mod_a_clk_q;
    logic mod_b_clk_q;
    logic mod_a_tick;
    logic mod_b_tick;
    logic [15:0] dec_a_cnt_q;
    logic [15:0] dec_b_cnt_q;
    logic dec_a_q;
    logic dec_b_q;

    logic [15:0] raw_current0;
    logic [15:0] raw_current1;
    logic signed [15:0] cur0;
    logic signed [15:0] cur1;
    logic signed [15:0] derived_d;
    logic signed [15:0] derived_q;
    logic signed [15:0] ph_a_q;
    logic signed [15:0] ph_b_q;
    logic signed [15:0] ph_c_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic rvalid_q;

    wire logic [15:0] filter_a_decimation = decim_q[`CAF_LO16_MSB:`CAF_LO16_LSB];
    wire logic [15:0] filter_b_decimation = decim_q[`CAF_HI16_MSB:`CAF_HI16_LSB];

    // Register writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mod_a_clock_divider_q <= `CAF_RST_MOD_DIV;
            mod_b_clock_divider_q <= `CAF_RST_MOD_DIV;
            decim_q <= `CAF_RST_DECIM;
            cal1_q <= `CAF_RST_CAL;
            cal0_q <= `CAF_RST_CAL;
            routing_q <= `CAF_RST_ROUTING;
            host_cur_q <= `CAF_RST_HOST_CUR;
            stage_q <= `CAF_RST_STAGE;
        end else if (reg_wr) begin
            case (reg_addr)
                `CAF_IDX_MOD_A_DIV: mod_a_clock_divider_q <= reg_wdata;
                `CAF_IDX_MOD_B_DIV: mod_b_clock_divider_q <= reg_wdata;
                `CAF_IDX_DECIM: decim_q <= reg_wdata;
                `CAF_IDX_CAL1: cal1_q <= reg_wdata;
                `CAF_IDX_CAL0: cal0_q <= reg_wdata;
                `CAF_IDX_ROUTING: routing_q <= reg_wdata;
                `CAF_IDX_HOST_CUR: host_cur_q <= reg_wdata;
                `CAF_IDX_STAGE_CFG: stage_q <= reg_wdata[`CAF_STAGE_MSB:`CAF_STAGE_LSB];
                default: ;
            endcase
        end
    end

    // Modulator clock A: half period of divider plus one system cycles
    assign mod_a_tick = (div_a_cnt_q >= mod_a_clock_divider_q);
    assign mod_b_tick = (div_b_cnt_q >= mod_b_clock_divider_q);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_a_cnt_q <= 32'h0000_0000;
            mod_a_clk_q <= 1'b0;
        end else if (mod_a_tick) begin
            div_a_cnt_q <= 32'h0000_0000;
            mod_a_clk_q <= ~mod_a_clk_q;
        end else begin
            div_a_cnt_q <= div_a_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_b_cnt_q <= 32'h0000_0000;
            mod_b_clk_q <= 1'b0;
        end else if (mod_b_tick) begin
            div_b_cnt_q <= 32'h0000_0000;
            mod_b_clk_q <= ~mod_b_clk_q;
        end else begin
            div_b_cnt_q <= div_b_cnt_q + 32'h0000_0001;
        end
    end

    // Decimation strobe A: PWM locked at zero, else every N modulator periods
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dec_a_cnt_q <= 16'h0000;
            dec_a_q <= 1'b0;
        end else if (filter_a_decimation == 16'h0000) begin
            dec_a_cnt_q <= 16'h0000;
            dec_a_q <= pwm_period_pulse;
        end else if (mod_a_tick && mod_a_clk_q) begin
            if (dec_a_cnt_q >= filter_a_decimation - 16'h0001) begin
                dec_a_cnt_q <= 16'h0000;
                dec_a_q <= 1'b1;
            end else begin
                dec_a_cnt_q <= dec_a_cnt_q + 16'h0001;
                dec_a_q <= 1'b0;
            end
        end else begin
            dec_a_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dec_b_cnt_q <= 16'h0000;
            dec_b_q <= 1'b0;
        end else if (filter_b_decimation == 16'h0000) begin
            dec_b_cnt_q <= 16'h0000;
            dec_b_q <= pwm_period_pulse;
        end else if (mod_b_tick && mod_b_clk_q) begin
            if (dec_b_cnt_q >= filter_b_decimation - 16'h0001) begin
                dec_b_cnt_q <= 16'h0000;
                dec_b_q <= 1'b1;
            end else begin
                dec_b_cnt_q <= dec_b_cnt_q + 16'h0001;
                dec_b_q <= 1'b0;
            end
        end else begin
            dec_b_q <= 1'b0;
        end
    end

    // Channel 0: source, offset and gain
    caf_cal_chan u_chan0 (
        .mclk(mclk),
        .rst_n(rst_n),
        .source_sel(routing_q[`CAF_RAW0_SEL_MSB:`CAF_RAW0_SEL_LSB]),
        .modulator0_result(modulator0_result),
        .modulator1_result(modulator1_result),
        .host_current0_value(host_cur_q[`CAF_LO16_MSB:`CAF_LO16_LSB]),
        .host_current1_value(host_cur_q[`CAF_HI16_MSB:`CAF_HI16_LSB]),
        .offset(cal0_q[`CAF_LO16_MSB:`CAF_LO16_LSB]),
        .gain(cal0_q[`CAF_HI16_MSB:`CAF_HI16_LSB]),
        .raw_current(raw_current0),
        .cal_current(cur0)
    );

    // Channel 1
    caf_cal_chan u_chan1 (
        .mclk(mclk),
        .rst_n(rst_n),
        .source_sel(routing_q[`CAF_RAW1_SEL_MSB:`CAF_RAW1_SEL_LSB]),
        .modulator0_result(modulator0_result),
        .modulator1_result(modulator1_result),
        .host_current0_value(host_cur_q[`CAF_LO16_MSB:`CAF_LO16_LSB]),
        .host_current1_value(host_cur_q[`CAF_HI16_MSB:`CAF_HI16_LSB]),
        .offset(cal1_q[`CAF_LO16_MSB:`CAF_LO16_LSB]),
        .gain(cal1_q[`CAF_HI16_MSB:`CAF_HI16_LSB]),
        .raw_current(raw_current1),
        .cal_current(cur1)
    );

    // Third current closes the sum of three phases to zero
    assign derived_d = 16'(-(cur0 + cur1));

    function automatic logic signed [15:0] pick_phase(
        input logic [1:0] sel,
        input logic signed [15:0] c0,
        input logic signed [15:0] c1,
        input logic signed [15:0] c2
    );
        case (sel)
            caf_pkg::CAF_PH_CUR0: pick_phase = c0;
            caf_pkg::CAF_PH_CUR1: pick_phase = c1;
            caf_pkg::CAF_PH_DERIVED: pick_phase = c2;
            default: pick_phase = 16'sh0000;
        endcase
    endfunction : pick_phase

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            derived_q <= 16'sh0000;
        end else begin
            derived_q <= derived_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ph_a_q <= 16'sh0000;
            ph_b_q <= 16'sh0000;
            ph_c_q <= 16'sh0000;
        end else begin
            ph_a_q <= pick_phase(routing_q[`CAF_PH_A_SEL_MSB:`CAF_PH_A_SEL_LSB],
                cur0, cur1, derived_d);
            ph_b_q <= pick_phase(routing_q[`CAF_PH_B_SEL_MSB:`CAF_PH_B_SEL_LSB],
                cur0, cur1, derived_d);
            ph_c_q <= pick_phase(routing_q[`CAF_PH_C_SEL_MSB:`CAF_PH_C_SEL_LSB],
                cur0, cur1, derived_d);
        end
    end

    // Register readback, unmapped reads give zero
    always_comb begin
        case (reg_addr)
            `CAF_IDX_MOD_A_DIV: rdata_d = mod_a_clock_divider_q;
            `CAF_IDX_MOD_B_DIV: rdata_d = mod_b_clock_divider_q;
            `CAF_IDX_DECIM: rdata_d = decim_q;
            `CAF_IDX_CAL1: rdata_d = cal1_q;
            `CAF_IDX_CAL0: rdata_d = cal0_q;
            `CAF_IDX_ROUTING: rdata_d = routing_q;
            `CAF_IDX_HOST_CUR: rdata_d = host_cur_q;
            `CAF_IDX_STAGE_CFG: rdata_d = {28'h000_0000, stage_q};
            `CAF_IDX_CAL_STATUS: rdata_d = {cur1, cur0};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign mod_a_clk = mod_a_clk_q;
    assign mod_b_clk = mod_b_clk_q;
    assign filter_a_dec_strobe = dec_a_q;
    assign filter_b_dec_strobe = dec_b_q;
    assign phase_a_current = ph_a_q;
    assign phase_b_current = ph_b_q;
    assign phase_c_current = ph_c_q;
    assign derived_third_current = derived_q;
    assign input_stage_config = stage_q;
endmodule : caf_frontend

// *** caf_frontend_checker.sv ***
// Concurrent checks on the current front end ports
`timescale 1ns/1ps
`include "caf_cfg.svh"
module caf_frontend_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic pwm_period_pulse,
    input wire logic mod_a_clk,
    input wire logic filter_a_dec_strobe,
    input wire logic signed [15:0] phase_a_current,
    input wire logic signed [15:0] phase_b_current,
    input wire logic signed [15:0] phase_c_current,
    input wire logic signed [15:0] derived_third_current,
    input wire logic [3:0] input_stage_config
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [31:0] div_q, dec_q, rt_q, run_q;
    logic prev_q, settled_q;
    logic [2:0] age_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_q <= 32'h0;
            dec_q <= 32'h0;
            rt_q <= `CAF_RST_ROUTING;
        end else if (reg_wr) begin
            if (reg_addr == `CAF_IDX_MOD_A_DIV) div_q <= reg_wdata;
            if (reg_addr == `CAF_IDX_DECIM) dec_q <= reg_wdata;
            if (reg_addr == `CAF_IDX_ROUTING) rt_q <= reg_wdata;
        end
    end
    // Cycles since the routing last changed
    always_ff @(posedge mclk) begin
        if (!rst_n || (reg_wr && reg_addr == `CAF_IDX_ROUTING)) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
    // Length of the current level of modulator clock A
    always_ff @(posedge mclk) begin
        prev_q <= mod_a_clk;
        run_q <= (mod_a_clk != prev_q) ? 32'h1 : run_q + 32'h1;
        if (!rst_n || (reg_wr && reg_addr == `CAF_IDX_MOD_A_DIV)) settled_q <= 1'b0;
        else if (mod_a_clk != prev_q) settled_q <= 1'b1;
    end
    a_read_answer: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after request");
    a_mod_clk_half: assert property (
        (mod_a_clk != prev_q) && settled_q |-> run_q == div_q + 32'h1)
        else $error("modulator clock half period wrong");
    a_dec_pwm_sync: assert property (
        dec_q[15:0] == 16'h0 |=> filter_a_dec_strobe == $past(pwm_period_pulse))
        else $error("decimation strobe not locked to pwm");
    a_stage_copy: assert property (
        reg_wr && reg_addr == `CAF_IDX_STAGE_CFG
        |=> input_stage_config == 4'($past(reg_wdata)))
        else $error("input stage config not updated");
    a_route_readback: assert property (
        (reg_wr && reg_addr == `CAF_IDX_ROUTING) ##2 (reg_rd && reg_addr == `CAF_IDX_ROUTING)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("routing readback wrong");
    a_derived_sum: assert property (
        age_q > 3'h3 && rt_q[25:24] == 2'h0 && rt_q[27:26] == 2'h1
        |-> derived_third_current == 16'(-(phase_a_current + phase_b_current)))
        else $error("derived current not minus sum");
    a_phase_c_derived: assert property (
        age_q > 3'h3 && rt_q[29:28] == 2'h2 |-> phase_c_current == derived_third_current)
        else $error("phase c not derived current");
    a_phase_a_unused: assert property (
        age_q > 3'h3 && rt_q[25:24] == 2'h3 |-> phase_a_current == 16'sh0)
        else $error("phase a code 3 not zero");
    a_phase_b_derived: assert property (
        age_q > 3'h3 && rt_q[27:26] == 2'h2 |-> phase_b_current == derived_third_current)
        else $error("phase b not derived current");
endmodule : caf_frontend_checker
bind caf_frontend caf_frontend_checker u_chk (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pwm_period_pulse(pwm_period_pulse), .mod_a_clk(mod_a_clk),
    .filter_a_dec_strobe(filter_a_dec_strobe), .phase_a_current(phase_a_current),
    .phase_b_current(phase_b_current), .phase_c_current(phase_c_current),
    .derived_third_current(derived_third_current), .input_stage_config(input_stage_config));

// *** caf_pkg.sv ***
// Types shared by the current front end
package caf_pkg;
    typedef enum logic [7:0] {
        CAF_RAW_MOD0 = 8'h00,
        CAF_RAW_MOD1 = 8'h01,
        CAF_RAW_HOST0 = 8'h02,
        CAF_RAW_HOST1 = 8'h03
    } caf_raw_sel_t;

    typedef enum logic [1:0] {
        CAF_PH_CUR0 = 2'h0,
        CAF_PH_CUR1 = 2'h1,
        CAF_PH_DERIVED = 2'h2
    } caf_phase_sel_t;

    typedef enum logic [3:0] {
        CAF_STAGE_DIFF = 4'h0,
        CAF_STAGE_GND_NEG = 4'h1,
        CAF_STAGE_QUARTER = 4'h2,
        CAF_STAGE_3QUARTER = 4'h3,
        CAF_STAGE_POS_GND = 4'h4,
        CAF_STAGE_HALF = 4'h5
    } caf_stage_t;
endpackage : caf_pkg

// *** test_caf_frontend.sv ***
// Self-checking bench for the current front end
`timescale 1ns/1ps
`include "caf_cfg.svh"
module test_caf_frontend;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pwm = 1'b0;
    logic [6:0] reg_addr = 7'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_rvalid, clk_a, clk_b, dec_a, dec_b;
    logic [15:0] m0 = 16'h0120;
    logic [15:0] m1 = 16'h0040;
    logic [15:0] h0 = 16'h0300;
    logic [15:0] h1 = 16'hfb00;
    logic [15:0] off0 = 16'h0;
    logic [15:0] off1 = 16'h0;
    logic signed [15:0] g0 = 16'sh0100;
    logic signed [15:0] g1 = 16'sh0100;
    logic signed [15:0] ph_a, ph_b, ph_c, der;
    logic [3:0] stage;
    logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, `CAF_RST_CAL, `CAF_RST_CAL, `CAF_RST_ROUTING,
        32'h0, 32'h0};
    int rt [5][5] = '{'{0, 1, 0, 1, 1}, '{1, 0, 1, 0, 2}, '{2, 3, 2, 2, 0}, '{3, 2, 3, 1, 2},
        '{0, 3, 2, 1, 3}};
    int sc [5] = '{0, 1, 2, 4, 5};
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int na, nb, nt;
    logic pb;
    caf_frontend dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .modulator0_result(m0), .modulator1_result(m1),
        .pwm_period_pulse(pwm), .mod_a_clk(clk_a), .mod_b_clk(clk_b),
        .filter_a_dec_strobe(dec_a), .filter_b_dec_strobe(dec_b), .phase_a_current(ph_a),
        .phase_b_current(ph_b), .phase_c_current(ph_c), .derived_third_current(der),
        .input_stage_config(stage));
    always #20 mclk = ~mclk;
    task end_of_test;
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk32
    task wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [6:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk32("rvalid", 32'h1, {31'h0, reg_rvalid});
        chk32("rdata", exp, reg_rdata);
    endtask : rd
    function automatic logic [15:0] rawv(input int s);
        case (s)
            1: rawv = m1;
            2: rawv = h0;
            3: rawv = h1;
            default: rawv = m0;
        endcase
    endfunction : rawv
    function automatic logic [15:0] calv(input logic [15:0] r, input logic [15:0] o,
        input logic signed [15:0] g);
        int d;
        d = int'(r) - int'(o);
        calv = 16'((d * int'(g)) >>> 8);
    endfunction : calv
    task paths(input int r0, input int r1, input int a, input int b, input int c);
        logic [15:0] p [4];
        wr(`CAF_IDX_ROUTING, 32'((c << 28) | (b << 26) | (a << 24) | (r1 << 8) | r0));
        repeat (5) @(posedge mclk);
        #1;
        p[0] = calv(rawv(r0), off0, g0);
        p[1] = calv(rawv(r1), off1, g1);
        p[2] = 16'(-(p[0] + p[1]));
        p[3] = 16'h0;
        chk32("phase_a", {16'h0, p[a]}, {16'h0, ph_a});
        chk32("phase_b", {16'h0, p[b]}, {16'h0, ph_b});
        chk32("phase_c", {16'h0, p[c]}, {16'h0, ph_c});
        chk32("derived", {16'h0, p[2]}, {16'h0, der});
        rd(`CAF_IDX_CAL_STATUS, {p[1], p[0]});
    endtask : paths
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(7'(5 + i), rv[i]);
        rd(7'h00, 32'h0);
        rd(7'h20, 32'h0);
        for (int i = 7; i < 12; i++) begin
            wr(7'(i), 32'h8421_7f3c + 32'(i));
            rd(7'(i), 32'h8421_7f3c + 32'(i));
            wr(7'(i), rv[i - 5]);
        end
        for (int i = 0; i < 5; i++) begin
            wr(`CAF_IDX_STAGE_CFG, 32'(sc[i]));
            #1;
            chk32("stage", 32'(sc[i]), {28'h0, stage});
        end
        wr(`CAF_IDX_HOST_CUR, {h1, h0});
        rd(`CAF_IDX_ROUTING, rv[5]);
        for (int i = 0; i < 5; i++) begin
            paths(rt[i][0], rt[i][1], rt[i][2], rt[i][3], rt[i][4]);
        end
        off0 = 16'h0020;
        g0 = 16'sh0200;
        off1 = 16'h0010;
        g1 = -16'sh0100;
        wr(`CAF_IDX_CAL0, {g0, off0});
        wr(`CAF_IDX_CAL1, {g1, off1});
        paths(0, 1, 0, 1, 2);
        paths(2, 3, 1, 2, 0);
        wr(`CAF_IDX_MOD_A_DIV, 32'h1);
        wr(`CAF_IDX_MOD_B_DIV, 32'h2);
        rd(`CAF_IDX_MOD_B_DIV, 32'h2);
        @(posedge mclk);
        pwm <= 1'b1;
        @(posedge mclk);
        pwm <= 1'b0;
        #1;
        chk32("pwm_strobes", 32'h3, {30'h0, dec_b, dec_a});
        wr(`CAF_IDX_DECIM, 32'h0003_0002);
        na = 0;
        nb = 0;
        nt = 0;
        #1;
        pb = clk_b;
        repeat (96) begin
            @(posedge mclk);
            #1;
            na += int'(dec_a);
            nb += int'(dec_b);
            nt += int'(clk_b != pb);
            pb = clk_b;
        end
        chk32("mod_b_toggles", 32'h20, 32'(nt));
        chk32("dec_a_rate", 32'h1, {31'h0, na >= 11 && na <= 13});
        chk32("dec_b_rate", 32'h1, {31'h0, nb >= 5 && nb <= 6});
        end_of_test();
    end
endmodule : test_caf_frontend
